// file: verilog/asrc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "asrc_params.svh"
// Function
// - behave as if input upsampled by 2^20
// - zero-stuff then low-pass to kill images
// - take closest sample on fine grid
// - one convolution per output strobe period
// - 64 taps when upsampling or equal rate
// - place strobe to 2^-20 input period
// - average coarse period counts over time
// - small coefficient table, interpolated per tap
// - decimating: scale start, amplitude, length
// - decimating: lower cutoff, longer convolution
// - buffer depth bounds the decimation ratio
// - 512-word buffer per channel
// - ram address down, coef step, end on wrap
module asrc_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  input wire asrc_pkg::asrc_sample_t in_left,
  input wire asrc_pkg::asrc_sample_t in_right,
  output logic in_ready,
  input wire logic out_strobe,
  output logic out_valid,
  output var asrc_pkg::asrc_sample_t out_left,
  output var asrc_pkg::asrc_sample_t out_right,
  output logic busy
);
  import asrc_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // kernel (1-x^2)^2 across the 64-period span, one entry per period
  function automatic logic [17:0] kernel_at(input int i);
    int x;
    x = `ASRC_HALF * `ASRC_HALF - (i - `ASRC_HALF) * (i - `ASRC_HALF);
    if (i > `ASRC_TAPS) begin
      x = 0;
    end
    return 18'((`ASRC_COEF_PEAK * x * x) >> 20); // 1024^2 scale
  endfunction

  // reduced table: 66 entries instead of one per fine phase
  logic [17:0] rom [0:`ASRC_TAPS+1];
  for (genvar g = 0; g <= `ASRC_TAPS + 1; g++) begin : g_rom
    assign rom[g] = kernel_at(g);
  end

  // fifo output side
  logic f_valid;
  logic f_ready;
  logic [2*`ASRC_DW-1:0] f_data;
  logic pop;
  logic in_tick; // sample accepted: this is the input sample instant

  asrc_fifo #(.WIDTH(2 * `ASRC_DW), .DEPTH(`ASRC_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(in_valid),
    .in_data({in_left, in_right}),
    .in_ready(in_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  // sequencer state
  asrc_state_t st, next_st;
  logic [15:0] elapsed, next_elapsed; // cycles since last input sample
  logic [16:0] rem, next_rem; // divider remainder
  logic [15:0] den, next_den; // divider divisor
  logic [19:0] quot, next_quot; // divider quotient
  logic [4:0] div_cnt, next_div_cnt;
  logic [19:0] frac, next_frac; // strobe phase, 2^-20 input periods
  logic [20:0] ratio, next_ratio; // fs_out/fs_in, 1.20 fixed point
  logic [26:0] coef_ptr, next_ptr; // bit 26 is the wrap flag
  logic [`ASRC_AW-1:0] rd_addr, next_rd;
  logic [9:0] taps, next_taps; // taps done
  logic phase, next_phase; // 0 left, 1 right: one shared multiplier
  logic signed [51:0] acc_l, next_acc_l, acc_r, next_acc_r;
  logic next_out_valid, next_busy;
  asrc_sample_t next_out_l, next_out_r;

  // period measurement, 16.4 fixed-point averages
  logic [15:0] cnt_in, next_cnt_in, cnt_out, next_cnt_out;
  logic [19:0] per_in, next_per_in, per_out, next_per_out;
  logic signed [20:0] d_in, d_out;
  logic decim; // output rate below input rate

  assign in_tick = in_valid && in_ready;
  assign decim = per_out[19:4] > per_in[19:4];

  // coarse counts, smoothed by a leaky average instead of a fast counter
  always_comb begin
    d_in = {1'b0, cnt_in, 4'h0} - {1'b0, per_in};
    d_out = {1'b0, cnt_out, 4'h0} - {1'b0, per_out};
    next_cnt_in = (cnt_in == `ASRC_CNT_MAX) ? cnt_in : cnt_in + 16'h1;
    next_cnt_out = (cnt_out == `ASRC_CNT_MAX) ? cnt_out : cnt_out + 16'h1;
    next_per_in = per_in;
    next_per_out = per_out;
    if (in_tick) begin
      next_cnt_in = 16'h1;
      next_per_in = per_in + 20'(d_in >>> `ASRC_AVG_SHIFT);
    end
    if (out_strobe) begin
      next_cnt_out = 16'h1;
      next_per_out = per_out + 20'(d_out >>> `ASRC_AVG_SHIFT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_in <= 16'h0;
      cnt_out <= 16'h0;
      per_in <= 20'(`ASRC_PER_RST);
      per_out <= 20'(`ASRC_PER_RST);
    end else begin
      cnt_in <= next_cnt_in;
      cnt_out <= next_cnt_out;
      per_in <= next_per_in;
      per_out <= next_per_out;
    end
  end

  avg_track_a: assert property ((in_tick && {cnt_in, 4'h0} > per_in) |=>
    per_in >= $past(per_in)) else $error("input period average moved away");

  // input buffer; ratio scaling keeps long convolutions from saturating
  asrc_sample_t ram_l [0:`ASRC_RAM_DEPTH-1];
  asrc_sample_t ram_r [0:`ASRC_RAM_DEPTH-1];
  logic [`ASRC_AW-1:0] wr_addr, next_wr_addr;
  logic signed [45:0] sc_l, sc_r;
  asrc_sample_t wr_l, wr_r;

  // drain while idle or in ST_DRAIN so the newest sample is in before a pass
  assign f_ready = (st == ST_IDLE) || (st == ST_DRAIN);
  assign pop = f_valid && f_ready;

  always_comb begin
    sc_l = $signed(f_data[2*`ASRC_DW-1:`ASRC_DW]) * $signed({1'b0, ratio});
    sc_r = $signed(f_data[`ASRC_DW-1:0]) * $signed({1'b0, ratio});
    wr_l = 24'(sc_l >>> `ASRC_FRAC_BITS);
    wr_r = 24'(sc_r >>> `ASRC_FRAC_BITS);
    next_wr_addr = pop ? wr_addr + 9'h1 : wr_addr;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_addr <= '0;
    end else begin
      wr_addr <= next_wr_addr;
    end
  end

  // samples scaled by the ratio current at write time
  always_ff @(posedge clk_sys) begin
    if (pop) begin
      ram_l[wr_addr] <= wr_l;
      ram_r[wr_addr] <= wr_r;
    end
  end

  scale_in_a: assert property ((pop && ratio == `ASRC_ONE) |->
    wr_l == $signed(f_data[2*`ASRC_DW-1:`ASRC_DW]))
    else $error("unity ratio altered stored sample");

  // quadratic interpolation between table entries at pointer fraction
  logic [5:0] c_idx;
  logic signed [17:0] y0, y1, y2, ts, h, coef;
  logic signed [35:0] p1, p2, p3;
  always_comb begin
    c_idx = coef_ptr[25:20];
    y0 = $signed(rom[{1'b0, c_idx}]);
    y1 = $signed(rom[{1'b0, c_idx} + 7'h1]);
    y2 = $signed(rom[{1'b0, c_idx} + 7'h2]);
    ts = $signed({2'b00, coef_ptr[19:4]});
    p1 = ts * (ts - 18'sh10000);
    h = 18'(p1 >>> 17);
    p2 = ts * (y1 - y0);
    p3 = h * (y2 - y1 - y1 + y0);
    coef = 18'(y0 + 18'(p2 >>> 16) + 18'(p3 >>> 16));
  end

  coef_grid_a: assert property ((st == ST_MAC && coef_ptr[19:0] == 20'h0) |->
    coef == $signed(rom[{1'b0, c_idx}]))
    else $error("coefficient off table at grid point");

  // shared multiplier, left on phase 0 and right on phase 1
  asrc_sample_t mul_s;
  logic signed [41:0] prod;
  assign mul_s = phase ? ram_r[rd_addr] : ram_l[rd_addr];
  assign prod = mul_s * coef;

  // divider step: restoring, one quotient bit per cycle
  logic [16:0] r2;
  logic q_bit;
  logic [19:0] q_now;
  logic [40:0] sh;

  always_comb begin
    next_st = st;
    next_elapsed = elapsed;
    next_rem = rem;
    next_den = den;
    next_quot = quot;
    next_div_cnt = div_cnt;
    next_frac = frac;
    next_ratio = ratio;
    next_ptr = coef_ptr;
    next_rd = rd_addr;
    next_taps = taps;
    next_phase = phase;
    next_acc_l = acc_l;
    next_acc_r = acc_r;
    next_out_valid = 1'b0;
    next_out_l = out_left;
    next_out_r = out_right;
    r2 = {rem[15:0], 1'b0};
    q_bit = (r2 >= {1'b0, den});
    q_now = {quot[18:0], q_bit};
    sh = frac * ratio;
    case (st)
      ST_IDLE: begin
        // strobes arriving while busy are not taken: one pass each
        if (out_strobe) begin
          next_elapsed = (cnt_in < per_in[19:4]) ? cnt_in :
            per_in[19:4] - 16'h1;
          next_st = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!f_valid) begin
          next_rem = {1'b0, elapsed};
          next_den = per_in[19:4];
          next_quot = '0;
          next_div_cnt = '0;
          next_st = ST_DIVF;
        end
      end
      ST_DIVF, ST_DIVR: begin
        next_rem = q_bit ? r2 - {1'b0, den} : r2;
        next_quot = q_now;
        next_div_cnt = div_cnt + 5'h1;
        if (div_cnt == 5'(`ASRC_FRAC_BITS - 1)) begin
          next_div_cnt = '0;
          next_quot = '0;
          next_st = ST_SETUP;
          if (st == ST_DIVF) begin
            next_frac = q_now;
            next_ratio = `ASRC_ONE;
            if (decim) begin
              next_rem = {1'b0, per_in[19:4]};
              next_den = per_out[19:4];
              next_st = ST_DIVR;
            end
          end else begin
            // floor keeps the pass inside the buffer
            next_ratio = (21'(q_now) < `ASRC_RATIO_MIN) ?
              `ASRC_RATIO_MIN : 21'(q_now);
          end
        end
      end
      ST_SETUP: begin
        // start phase scaled by ratio when decimating
        next_ptr = 27'(sh >> `ASRC_FRAC_BITS);
        next_rd = wr_addr - 9'(`ASRC_GROUP_OFS) - 9'h1;
        next_taps = '0;
        next_phase = 1'b0;
        next_acc_l = '0;
        next_acc_r = '0;
        next_st = ST_MAC;
      end
      ST_MAC: begin
        if (!phase) begin
          next_acc_l = acc_l + 52'(prod);
          next_phase = 1'b1;
        end else begin
          next_acc_r = acc_r + 52'(prod);
          next_phase = 1'b0;
          next_rd = rd_addr - 9'h1;
          next_ptr = coef_ptr + 27'(ratio);
          next_taps = taps + 10'h1;
          if (next_ptr[26] || next_taps == 10'(`ASRC_MAX_TAPS)) begin
            next_st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_out_l = acc_l[`ASRC_COEF_SH+23:`ASRC_COEF_SH];
        next_out_r = acc_r[`ASRC_COEF_SH+23:`ASRC_COEF_SH];
        next_out_valid = 1'b1;
        next_st = ST_IDLE;
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    next_busy = (next_st != ST_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= ST_IDLE;
      elapsed <= '0;
      rem <= '0;
      den <= '0;
      quot <= '0;
      div_cnt <= '0;
      frac <= '0;
      ratio <= `ASRC_ONE;
      coef_ptr <= '0;
      rd_addr <= '0;
      taps <= '0;
      phase <= 1'b0;
      acc_l <= '0;
      acc_r <= '0;
      out_valid <= 1'b0;
      out_left <= '0;
      out_right <= '0;
      busy <= 1'b0;
    end else begin
      st <= next_st;
      elapsed <= next_elapsed;
      rem <= next_rem;
      den <= next_den;
      quot <= next_quot;
      div_cnt <= next_div_cnt;
      frac <= next_frac;
      ratio <= next_ratio;
      coef_ptr <= next_ptr;
      rd_addr <= next_rd;
      taps <= next_taps;
      phase <= next_phase;
      acc_l <= next_acc_l;
      acc_r <= next_acc_r;
      out_valid <= next_out_valid;
      out_left <= next_out_l;
      out_right <= next_out_r;
      busy <= next_busy;
    end
  end

  strobe_take_a: assert property ((st == ST_IDLE && out_strobe) |=> busy)
    else $error("output strobe not taken");
  one_conv_a: assert property ((st == ST_DONE) |=>
    (out_valid && !busy && st == ST_IDLE))
    else $error("pass end without one output");
  frac_res_a: assert property ((st == ST_DIVF && div_cnt == 5'h13) |=>
    (37'(frac) * 37'($past(den)) <= {1'b0, $past(elapsed), 20'h0}) &&
    ({1'b0, $past(elapsed), 20'h0} < (37'(frac) + 37'h1) * 37'($past(den))))
    else $error("strobe phase not floor of ratio");
  taps_unity_a: assert property ((st == ST_DONE && ratio == `ASRC_ONE) |->
    taps == 10'h40) else $error("unity pass not 64 taps");
  decim_long_a: assert property ((st == ST_DONE && ratio < `ASRC_ONE) |->
    taps >= 10'h40) else $error("decimating pass too short");
  ratio_floor_a: assert property (ratio >= `ASRC_RATIO_MIN)
    else $error("ratio below buffer limit");
  tap_limit_a: assert property ((st == ST_DONE) |-> taps <= 10'h1f0)
    else $error("pass longer than buffer allows");
  start_pos_a: assert property ((st == ST_SETUP) |=>
    coef_ptr < 27'h100000) else $error("start beyond one phase");
  rd_dec_a: assert property ((st == ST_MAC && phase) |=>
    rd_addr == $past(rd_addr) - 9'h1)
    else $error("read address not stepped down");
  ptr_step_a: assert property ((st == ST_MAC && phase) |=>
    coef_ptr == $past(coef_ptr) + 27'($past(ratio)))
    else $error("coefficient pointer step wrong");
  no_wrap_a: assert property ((st == ST_MAC) |-> !coef_ptr[26])
    else $error("pass continued after pointer wrap");
endmodule
`default_nettype wire

// file: verilog/asrc_params.svh
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
// sample width and conceptual interpolation (2^20 fine grid)
`define ASRC_DW 24
`define ASRC_FRAC_BITS 20
`define ASRC_ONE 21'h100000
// filter length at unity or upsampling, and half span of the kernel
`define ASRC_TAPS 64
`define ASRC_HALF 32
// input sample buffer and read/write offset
`define ASRC_RAM_DEPTH 512
`define ASRC_AW 9
`define ASRC_GROUP_OFS 16
`define ASRC_MAX_TAPS (`ASRC_RAM_DEPTH - `ASRC_GROUP_OFS)
// smallest ratio: ceil(64 * 2^20 / 496)
`define ASRC_RATIO_MIN 21'h21085
// coefficient peak and output scaling shift
`define ASRC_COEF_PEAK 961
`define ASRC_COEF_SH 15
// period averaging, 16.4 fixed point, start estimate at 48 kHz
`define ASRC_AVG_SHIFT 3
`define ASRC_CLK_MHZ 200
`define ASRC_FS_RST_KHZ 48
`define ASRC_PER_RST (((`ASRC_CLK_MHZ * 1000 + `ASRC_FS_RST_KHZ - 1) / `ASRC_FS_RST_KHZ) * 16)
`define ASRC_CNT_MAX 16'hffff
`define ASRC_FIFO_DEPTH 4
`endif

// file: verilog/asrc_pkg.sv
package asrc_pkg;
  // one audio sample, two's complement
  typedef logic signed [23:0] asrc_sample_t;
  // converter sequencing
  typedef enum logic [2:0] {
    ST_IDLE, ST_DRAIN, ST_DIVF, ST_DIVR, ST_SETUP, ST_MAC, ST_DONE
  } asrc_state_t;
endpackage

// file: verilog/asrc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4 // power of two: pointers wrap freely
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count; // words held
  logic next_in_ready, next_out_valid, push, pop;

  assign out_data = mem[rd_ptr];

  // pointers and flags; flags registered so ready never loops back
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
    next_in_ready = (next_count != CW'(DEPTH));
    next_out_valid = (next_count != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  // data store
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: verification/asrc_partner.sv
`timescale 1ns/1ps
`default_nettype none
// audio source at the converter's input: offers one stereo word on a
// cycle grid set by the bench and holds it while it is refused
module asrc_partner (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] cyc,
  input wire logic on,
  input wire logic rand_on,
  input wire logic [15:0] period,
  input wire logic [15:0] ofs,
  input wire logic in_ready,
  output logic in_valid,
  output var asrc_pkg::asrc_sample_t in_left,
  output var asrc_pkg::asrc_sample_t in_right,
  output logic [31:0] taken,
  output logic [31:0] stalls
);
  import asrc_pkg::*;
  // xorshift state, fixed start so every run offers the same words
  logic [31:0] rnd;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  // one word per grid slot; an idle bus toggles so no stale value
  // can pass for data; reset seeds bus and xorshift state from one
  // process so nothing has two drivers
  always @(posedge clk_sys) begin
    if (rst) begin
      in_valid <= 1'b0;
      in_left <= 24'h5a5a5a;
      in_right <= 24'ha5a5a5;
      rnd <= 32'h3b6;
      taken <= 32'h0;
      stalls <= 32'h0;
    end else if (in_valid && in_ready) begin
      // taken at this edge: release and scramble the bus
      in_valid <= 1'b0;
      in_left <= ~in_left;
      in_right <= ~in_right;
      taken <= taken + 32'h1;
    end else if (in_valid) begin
      // refused: word and valid stay as they are
      stalls <= stalls + 32'h1;
    end else if (on && (cyc % period) == ofs) begin
      in_valid <= 1'b1;
      in_left <= rand_on ? rnd[23:0] : 24'h0;
      in_right <= rand_on ? rnd[31:8] : 24'h0;
      rnd <= xs(rnd);
    end else begin
      in_left <= ~in_left;
      in_right <= ~in_right;
    end
  end
endmodule
`default_nettype wire

// file: verification/asrc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_core_test;
  import asrc_pkg::*;
  // one accepted strobe: drive cycle, latency window, zero data flag
  typedef struct {
    logic [31:0] t;
    int lo;
    int hi;
    logic zero;
  } asrc_exp_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic out_strobe = 1'b0;
  logic in_valid;
  asrc_sample_t in_left;
  asrc_sample_t in_right;
  logic in_ready;
  logic out_valid;
  logic busy;
  asrc_sample_t out_left;
  asrc_sample_t out_right;
  logic [31:0] cyc = 32'h0; // free cycle count, shared grid
  logic src_on = 1'b0;
  logic src_rand = 1'b0;
  logic [15:0] src_per = 16'h1;
  logic [15:0] src_ofs = 16'h0;
  logic [31:0] taken;
  logic [31:0] stalls;
  int err_count = 0;
  int checks_done = 0;
  asrc_exp_t exp_q[$]; // notes of outputs still owed
  asrc_exp_t e;
  int lat;
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 32'h1;
  asrc_core uut (
    .clk_sys(clk_sys), .rst(rst), .in_valid(in_valid),
    .in_left(in_left), .in_right(in_right), .in_ready(in_ready),
    .out_strobe(out_strobe), .out_valid(out_valid),
    .out_left(out_left), .out_right(out_right), .busy(busy)
  );
  asrc_partner src (
    .clk_sys(clk_sys), .rst(rst), .cyc(cyc), .on(src_on),
    .rand_on(src_rand), .period(src_per), .ofs(src_ofs),
    .in_ready(in_ready), .in_valid(in_valid), .in_left(in_left),
    .in_right(in_right), .taken(taken), .stalls(stalls)
  );
  task check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // strobes on a grid of per cycles; a slot is skipped while a result is
  // still owed, so each strobe issued here is one the sequencer takes
  task run(input int per, input int n, input int lo, input int hi,
           input logic zero);
    for (int i = 0; i < n; i++) begin
      do @(posedge clk_sys); while ((cyc % per) != 0);
      if (exp_q.size() == 0) begin
        out_strobe <= 1'b1;
        exp_q.push_back('{cyc, lo, hi, zero});
        @(posedge clk_sys);
        out_strobe <= 1'b0;
      end
    end
  endtask
  // result watcher: every out_valid pulse settles the oldest note
  always @(posedge clk_sys) begin
    if (!rst && out_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "result without a taken strobe");
      end else begin
        e = exp_q.pop_front();
        lat = int'(cyc - e.t) - 1;
        check(lat >= e.lo && lat <= e.hi, "pass length off");
        if (e.zero) begin
          check(out_left === 24'h0 && out_right === 24'h0, "not silent");
        end
      end
    end
  end
  // hang guard, about half again the planned run
  initial begin
    #(90000 * 5);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    check(in_ready === 1'b0 && busy === 1'b0 && out_valid === 1'b0 &&
          out_left === 24'h0, "outputs not cleared in reset");
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(in_ready === 1'b1, "not ready after reset");
    // fill the whole 512-word buffer with silence, one word every other cycle
    src_on <= 1'b1;
    for (int i = 0; i < 4000 && taken < 32'h258; i++) @(posedge clk_sys);
    check(taken >= 32'h258, "buffer fill stalled");
    // upsampling: input every 400 cycles, strobes every 200, input slot
    // kept clear of the pass so the fifo is empty at each strobe
    src_per <= 16'd400;
    src_ofs <= 16'd170;
    run(200, 110, 152, 1100, 1'b1);
    run(200, 15, 152, 152, 1'b1);
    // decimating with random audio: input slots every 100 cycles,
    // strobes every 2400; the fifo fills and refuses during a pass, so
    // the measured input period is longer than the slot grid, yet the
    // ratio stays under the floor and the pass sits at 496 taps; the
    // fifo is empty again at every strobe, so no drain cycles
    src_rand <= 1'b1;
    src_per <= 16'h64;
    src_ofs <= 16'h3;
    run(2400, 5, 152, 1100, 1'b0);
    run(2400, 8, 1036, 1044, 1'b0);
    check(stalls != 32'h0, "source never refused");
    // a strobe during a pass is dropped and owes no result
    run(1200, 1, 152, 1100, 1'b0);
    repeat (100) @(posedge clk_sys);
    check(busy === 1'b1, "pass not running");
    out_strobe <= 1'b1;
    @(posedge clk_sys);
    out_strobe <= 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) begin
      @(posedge clk_sys);
    end
    repeat (1300) @(posedge clk_sys);
    check(exp_q.size() == 0, "result missing");
    stop_test();
  end
endmodule
`default_nettype wire
